// ### common/timing_loopback_pkg.sv
// Constants and carrier types for the timing and loopback register bank.
// Assumes an AXI4-Lite master with 32-bit data and byte addresses of 4 x index.
package timing_loopback_pkg;

   // ********************************************************************
   // Bus geometry
   // ********************************************************************
   localparam int ADDR_W = 8;
   localparam int REG_W = 8;
   localparam int IDX_LSB = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ********************************************************************
   // Register indices (byte address is four times the index)
   // ********************************************************************
   localparam logic [5:0] IDX_MASTER_IRQ_STATUS = 6'h02;
   localparam logic [5:0] IDX_TIMING_LOOPBACK_CONTROL = 6'h05;
   localparam logic [5:0] IDX_SYNTH_LOCK_CONTROL_STATUS = 6'h06;
   localparam logic [5:0] IDX_RECOVERY_LOCK_CONTROL_STATUS = 6'h08;
   localparam logic [5:0] IDX_RECOVERY_CONFIGURATION = 6'h09;
   localparam logic [5:0] IDX_LINE_DRIVER_CONFIGURATION = 6'h0A;

   // ********************************************************************
   // Reset values and writable masks
   // ********************************************************************
   localparam logic [7:0] CTRL_RESET = 8'h20;
   localparam logic [7:0] CTRL_WMASK = 8'hBF;
   localparam logic [7:0] SYNTH_RESET = 8'h00;
   localparam logic [7:0] SYNTH_WMASK = 8'h83;
   localparam logic [7:0] RECOV_RESET = 8'h00;
   localparam logic [7:0] RECOV_WMASK = 8'h87;
   localparam logic [7:0] CFG_RESET = 8'h07;
   localparam logic [7:0] CFG_WMASK = 8'h07;
   localparam logic [7:0] LDRV_RESET = 8'h2C;
   localparam logic [7:0] LDRV_WMASK = 8'hBF;

   // ********************************************************************
   // Field positions
   // ********************************************************************
   localparam int CTRL_LOOP_TIMING = 0;
   localparam int CTRL_SERIAL_LOOP = 1;
   localparam int CTRL_LINE_LOOP = 2;
   localparam int CTRL_PARALLEL_LOOP = 3;
   localparam int CTRL_PAIR_LOOP = 4;
   localparam int CTRL_FIXED_PTR = 5;
   localparam int CTRL_LCD_STATE = 6;
   localparam int CTRL_LCD_IRQ_EN = 7;
   localparam int SYNTH_IRQ_EN = 1;
   localparam int SYNTH_STATE = 3;
   localparam int SYNTH_FLAG = 5;
   localparam int RECOV_DATA_EN = 1;
   localparam int RECOV_REF_EN = 2;
   localparam int RECOV_DATA_STATE = 3;
   localparam int RECOV_REF_STATE = 4;
   localparam int RECOV_DATA_FLAG = 5;
   localparam int RECOV_REF_FLAG = 6;
   localparam int MIS_CRU = 5;
   localparam int MIS_LCD = 6;
   localparam int MIS_CSU = 7;
   localparam int LDRV_QUIET = 4;
   localparam int LDRV_DRIVE = 5;
   localparam int LDRV_BIAS = 7;

   // Lock inputs, one bit each
   localparam int LOCK_SYNTH = 0;
   localparam int LOCK_RX_DATA = 1;
   localparam int LOCK_RX_REF = 2;

   // ********************************************************************
   // Timing
   // ********************************************************************
   localparam logic [9:0] FIXED_POINTER_VALUE = 10'h20A;
   localparam int CLK_KHZ = 40000;
   localparam int LCD_PERSIST_US = 4000;
   localparam logic [17:0] LCD_PERSIST_CYCLES = 18'(LCD_PERSIST_US * CLK_KHZ / 1000);

   // ********************************************************************
   // Carriers
   // ********************************************************************
   typedef struct packed {
      logic [7:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [7:0] araddr;
      logic arvalid;
      logic rready;
   } axi_req_type;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axi_resp_type;

   typedef struct packed {
      logic txUseRecovered;
      logic serialLoop;
      logic lineLoop;
      logic parallelLoop;
      logic pairLoop;
      logic [9:0] payloadPointer;
      logic txQuiet;
      logic txDrive;
      logic biasRefExt;
   } line_ctrl_type;

endpackage

// ### hw/timing_loopback_ctrl.sv
// Timing, loopback and lock status register bank with its interrupt output.
// Assumes lock detectors drive levels from outside this clock, and the cell
// delineation and pointer inputs come from logic on sys_clk.
//
// Behaviour
// [R1] Loop timing off: transmit timed from reference
// [R2] Loop timing on: recovered clock unless data unlocked
// [R3] Software sets one loop timing/loopback mode only
// [R4] Serial diagnostic loopback routes transmit into receive
// [R5] Line loopback returns received line data outward
// [R6] Parallel loopback between transmit and receive overhead
// [R7] Pair loopback through line receiver and transmitter
// [R8] Fixed pointer holds 522, else pointer control
// [R9] Cell delineation loss after 4ms, cleared after 4ms
// [R10] Cell delineation change drives interrupt when enabled
// [R11] Synthesis lock change raises interrupt when enabled
// [R12] Synthesis unlock reported beyond 488 ppm
// [R13] Synthesis flag set on change, read clears
// [R14] Receive lock changes raise interrupts when enabled
// [R15] Receive data unlock: 488 ppm or no transitions
// [R16] Receive reference unlock while PLL not locked
// [R17] Software polls reference unlock after power-up
// [R18] Receive flags set on change, read clears
// [R19] Quiet mode splits transmit current equally
// [R20] Drive disable puts transmit outputs high impedance
// [R21] Bias reference: internal at zero, external at one
// [R22] Software keeps reserved bits at defaults
// [R23] Master cell delineation flag, cleared on read
// [R24] Interrupt output active low when anything pending
// [R25] Interrupt held while any enabled flag set
`timescale 1ns/100ps

module timing_loopback_ctrl #(
   parameter logic [17:0] LCD_PERSIST_CYCLES = timing_loopback_pkg::LCD_PERSIST_CYCLES
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire timing_loopback_pkg::axi_req_type axiReq,
   output timing_loopback_pkg::axi_resp_type axiResp,
   input wire logic [2:0] lockDetectIn,
   input wire logic cellOutOfDelin,
   input wire logic lowerAlarm,
   input wire logic [9:0] pointerCtrlIn,
   output timing_loopback_pkg::line_ctrl_type lineCtrl,
   output logic irqOutN
);

   // ********************************************************************
   // Reset release
   // ********************************************************************
   // Release edge synchronous to sys_clk
   logic [1:0] rstSync_reg;
   logic rstN;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rstSync_reg <= 2'h0;
      end else begin
         rstSync_reg <= {rstSync_reg[0], 1'b1};
      end
   end

   assign rstN = rstSync_reg[1];

   // ********************************************************************
   // State
   // ********************************************************************
   typedef struct packed {
      timing_loopback_pkg::axi_resp_type bus;
      logic awHeld;
      logic [5:0] awIdx;
      logic wHeld;
      logic [7:0] wData;
      logic wLane0;
      logic [7:0] ctrl;
      logic [7:0] synth;
      logic [7:0] recov;
      logic [7:0] cfg;
      logic [7:0] lineDrv;
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic [2:0] sync3;
      logic [2:0] lockState;
      logic [2:0] lockFlag;
      logic lcdState;
      logic lcdFlag;
      logic [17:0] lcdCnt;
      timing_loopback_pkg::line_ctrl_type out;
      logic irqN;
   } state_type;

   state_type state_reg;
   state_type state_next;

   localparam state_type STATE_RESET = '{
      bus: '0,
      awHeld: 1'b0,
      awIdx: '0,
      wHeld: 1'b0,
      wData: '0,
      wLane0: 1'b0,
      ctrl: timing_loopback_pkg::CTRL_RESET,
      synth: timing_loopback_pkg::SYNTH_RESET,
      recov: timing_loopback_pkg::RECOV_RESET,
      cfg: timing_loopback_pkg::CFG_RESET,
      lineDrv: timing_loopback_pkg::LDRV_RESET,
      sync1: '0,
      sync2: '0,
      sync3: '0,
      lockState: '0,
      lockFlag: '0,
      lcdState: 1'b0,
      lcdFlag: 1'b0,
      lcdCnt: '0,
      out: '{txUseRecovered: 1'b0, serialLoop: 1'b0, lineLoop: 1'b0, parallelLoop: 1'b0,
             pairLoop: 1'b0, payloadPointer: timing_loopback_pkg::FIXED_POINTER_VALUE,
             txQuiet: 1'b0, txDrive: 1'b1, biasRefExt: 1'b0},
      irqN: 1'b1
   };

   // ********************************************************************
   // Next state
   // ********************************************************************
   always_comb begin
      logic [2:0] lockNew;
      logic [2:0] lockChange;
      logic [2:0] lockClr;
      logic lcdClr;
      logic lcdCond;
      logic lcdChange;
      logic [5:0] rdIdx;
      logic [7:0] rdByte;
      logic rdHit;
      logic wrHit;
      logic doWrite;
      logic doRead;
      logic [7:0] misByte;
      logic synthPend;
      logic cruPend;
      logic lcdPend;
      lockNew = '0;
      lockChange = '0;
      lockClr = '0;
      lcdClr = 1'b0;
      lcdCond = 1'b0;
      lcdChange = 1'b0;
      rdIdx = '0;
      rdByte = '0;
      rdHit = 1'b0;
      wrHit = 1'b0;
      doWrite = 1'b0;
      doRead = 1'b0;
      misByte = '0;
      synthPend = 1'b0;
      cruPend = 1'b0;
      lcdPend = 1'b0;
      state_next = state_reg;

      // Lock inputs: a change counts once stages two and three agree
      state_next.sync1 = lockDetectIn;
      state_next.sync2 = state_reg.sync1;
      state_next.sync3 = state_reg.sync2;
      lockNew = (state_reg.sync2 & state_reg.sync3)
              | (state_reg.lockState & (state_reg.sync2 | state_reg.sync3)); // [R12] [R15] [R16]
      lockChange = lockNew ^ state_reg.lockState;
      state_next.lockState = lockNew;

      // Each direction needs an unbroken persistence period
      if (state_reg.lcdState) begin
         lcdCond = !cellOutOfDelin;
      end else begin
         lcdCond = cellOutOfDelin && !lowerAlarm;
      end
      if (!lcdCond) begin
         state_next.lcdCnt = '0;
      end else if (state_reg.lcdCnt == LCD_PERSIST_CYCLES - 18'h00001) begin
         state_next.lcdCnt = '0;
         lcdChange = 1'b1;
         state_next.lcdState = !state_reg.lcdState; // [R9]
      end else begin
         state_next.lcdCnt = state_reg.lcdCnt + 18'h00001;
      end

      // Pending terms; master status shows the synth and receive ones, but the raw delineation flag
      lcdPend = state_reg.lcdFlag & state_reg.ctrl[timing_loopback_pkg::CTRL_LCD_IRQ_EN];
      synthPend = state_reg.lockFlag[timing_loopback_pkg::LOCK_SYNTH]
                & state_reg.synth[timing_loopback_pkg::SYNTH_IRQ_EN];
      cruPend = (state_reg.lockFlag[timing_loopback_pkg::LOCK_RX_DATA]
                 & state_reg.recov[timing_loopback_pkg::RECOV_DATA_EN])
              | (state_reg.lockFlag[timing_loopback_pkg::LOCK_RX_REF]
                 & state_reg.recov[timing_loopback_pkg::RECOV_REF_EN]);
      misByte[timing_loopback_pkg::MIS_LCD] = state_reg.lcdFlag;
      misByte[timing_loopback_pkg::MIS_CSU] = synthPend;
      misByte[timing_loopback_pkg::MIS_CRU] = cruPend;

      // Write channels, taken in either order
      if (axiReq.awvalid && state_reg.bus.awready) begin
         state_next.awHeld = 1'b1;
         state_next.awIdx =
            axiReq.awaddr[timing_loopback_pkg::ADDR_W-1:timing_loopback_pkg::IDX_LSB];
      end
      if (axiReq.wvalid && state_reg.bus.wready) begin
         state_next.wHeld = 1'b1;
         state_next.wData = axiReq.wdata[timing_loopback_pkg::REG_W-1:0];
         state_next.wLane0 = axiReq.wstrb[0];
      end
      doWrite = state_reg.awHeld && state_reg.wHeld && !state_reg.bus.bvalid;
      if (doWrite) begin
         state_next.awHeld = 1'b0;
         state_next.wHeld = 1'b0;
         state_next.bus.bvalid = 1'b1;
         wrHit = 1'b1;
         case (state_reg.awIdx)
            timing_loopback_pkg::IDX_MASTER_IRQ_STATUS: begin
            end
            timing_loopback_pkg::IDX_TIMING_LOOPBACK_CONTROL: begin
               if (state_reg.wLane0) begin
                  state_next.ctrl = state_reg.wData & timing_loopback_pkg::CTRL_WMASK;
               end
            end
            timing_loopback_pkg::IDX_SYNTH_LOCK_CONTROL_STATUS: begin
               if (state_reg.wLane0) begin
                  state_next.synth = state_reg.wData & timing_loopback_pkg::SYNTH_WMASK;
               end
            end
            timing_loopback_pkg::IDX_RECOVERY_LOCK_CONTROL_STATUS: begin
               if (state_reg.wLane0) begin
                  state_next.recov = state_reg.wData & timing_loopback_pkg::RECOV_WMASK;
               end
            end
            timing_loopback_pkg::IDX_RECOVERY_CONFIGURATION: begin
               if (state_reg.wLane0) begin
                  state_next.cfg = state_reg.wData & timing_loopback_pkg::CFG_WMASK;
               end
            end
            timing_loopback_pkg::IDX_LINE_DRIVER_CONFIGURATION: begin
               if (state_reg.wLane0) begin
                  state_next.lineDrv = state_reg.wData & timing_loopback_pkg::LDRV_WMASK;
               end
            end
            default: begin
               wrHit = 1'b0;
            end
         endcase
         state_next.bus.bresp = wrHit ? timing_loopback_pkg::RESP_OKAY
                                      : timing_loopback_pkg::RESP_SLVERR;
      end
      if (state_reg.bus.bvalid && axiReq.bready) begin
         state_next.bus.bvalid = 1'b0;
      end
      state_next.bus.awready = !state_next.awHeld && !state_next.bus.bvalid;
      state_next.bus.wready = !state_next.wHeld && !state_next.bus.bvalid;

      // Read channel; a taken read clears the flags it shows, but a master status read leaves lock flags set
      doRead = axiReq.arvalid && state_reg.bus.arready;
      if (doRead) begin
         rdIdx = axiReq.araddr[timing_loopback_pkg::ADDR_W-1:timing_loopback_pkg::IDX_LSB];
         rdHit = 1'b1;
         case (rdIdx)
            timing_loopback_pkg::IDX_MASTER_IRQ_STATUS: begin
               rdByte = misByte;
               lcdClr = 1'b1; // [R23]
            end
            timing_loopback_pkg::IDX_TIMING_LOOPBACK_CONTROL: begin
               rdByte = state_reg.ctrl;
               rdByte[timing_loopback_pkg::CTRL_LCD_STATE] = state_reg.lcdState;
            end
            timing_loopback_pkg::IDX_SYNTH_LOCK_CONTROL_STATUS: begin
               rdByte = state_reg.synth;
               rdByte[timing_loopback_pkg::SYNTH_STATE] =
                  state_reg.lockState[timing_loopback_pkg::LOCK_SYNTH];
               rdByte[timing_loopback_pkg::SYNTH_FLAG] =
                  state_reg.lockFlag[timing_loopback_pkg::LOCK_SYNTH];
               lockClr[timing_loopback_pkg::LOCK_SYNTH] = 1'b1; // [R13]
            end
            timing_loopback_pkg::IDX_RECOVERY_LOCK_CONTROL_STATUS: begin
               rdByte = state_reg.recov;
               rdByte[timing_loopback_pkg::RECOV_DATA_STATE] =
                  state_reg.lockState[timing_loopback_pkg::LOCK_RX_DATA];
               rdByte[timing_loopback_pkg::RECOV_REF_STATE] =
                  state_reg.lockState[timing_loopback_pkg::LOCK_RX_REF];
               rdByte[timing_loopback_pkg::RECOV_DATA_FLAG] =
                  state_reg.lockFlag[timing_loopback_pkg::LOCK_RX_DATA];
               rdByte[timing_loopback_pkg::RECOV_REF_FLAG] =
                  state_reg.lockFlag[timing_loopback_pkg::LOCK_RX_REF];
               lockClr[timing_loopback_pkg::LOCK_RX_DATA] = 1'b1; // [R18]
               lockClr[timing_loopback_pkg::LOCK_RX_REF] = 1'b1; // [R18]
            end
            timing_loopback_pkg::IDX_RECOVERY_CONFIGURATION: begin
               rdByte = state_reg.cfg;
            end
            timing_loopback_pkg::IDX_LINE_DRIVER_CONFIGURATION: begin
               rdByte = state_reg.lineDrv;
            end
            default: begin
               rdHit = 1'b0;
            end
         endcase
         state_next.bus.rvalid = 1'b1;
         state_next.bus.rdata = {24'h000000, rdByte};
         state_next.bus.rresp = rdHit ? timing_loopback_pkg::RESP_OKAY
                                      : timing_loopback_pkg::RESP_SLVERR;
      end else if (state_reg.bus.rvalid && axiReq.rready) begin
         state_next.bus.rvalid = 1'b0;
      end
      state_next.bus.arready = !state_next.bus.rvalid;

      // Set beats clear in the clearing cycle
      state_next.lockFlag = (state_reg.lockFlag & ~lockClr) | lockChange; // [R13] [R18]
      state_next.lcdFlag = (state_reg.lcdFlag & ~lcdClr) | lcdChange; // [R23]

      // Line side controls follow the newest register values
      state_next.out.txUseRecovered = state_next.ctrl[timing_loopback_pkg::CTRL_LOOP_TIMING]
         & ~state_next.lockState[timing_loopback_pkg::LOCK_RX_DATA]; // [R1] [R2]
      state_next.out.serialLoop = state_next.ctrl[timing_loopback_pkg::CTRL_SERIAL_LOOP]; // [R4]
      state_next.out.lineLoop = state_next.ctrl[timing_loopback_pkg::CTRL_LINE_LOOP]; // [R5]
      state_next.out.parallelLoop =
         state_next.ctrl[timing_loopback_pkg::CTRL_PARALLEL_LOOP]; // [R6]
      state_next.out.pairLoop = state_next.ctrl[timing_loopback_pkg::CTRL_PAIR_LOOP]; // [R7]
      state_next.out.payloadPointer = state_next.ctrl[timing_loopback_pkg::CTRL_FIXED_PTR]
         ? timing_loopback_pkg::FIXED_POINTER_VALUE : pointerCtrlIn; // [R8]
      state_next.out.txQuiet = state_next.lineDrv[timing_loopback_pkg::LDRV_QUIET]; // [R19]
      state_next.out.txDrive = state_next.lineDrv[timing_loopback_pkg::LDRV_DRIVE]; // [R20]
      state_next.out.biasRefExt = state_next.lineDrv[timing_loopback_pkg::LDRV_BIAS]; // [R21]

      // Low while any enabled flag stays set; no pulse to miss
      state_next.irqN = !(
         (state_next.lcdFlag & state_next.ctrl[timing_loopback_pkg::CTRL_LCD_IRQ_EN]) // [R10]
         | (state_next.lockFlag[timing_loopback_pkg::LOCK_SYNTH]
            & state_next.synth[timing_loopback_pkg::SYNTH_IRQ_EN]) // [R11]
         | (state_next.lockFlag[timing_loopback_pkg::LOCK_RX_DATA]
            & state_next.recov[timing_loopback_pkg::RECOV_DATA_EN]) // [R14]
         | (state_next.lockFlag[timing_loopback_pkg::LOCK_RX_REF]
            & state_next.recov[timing_loopback_pkg::RECOV_REF_EN])); // [R14] [R24] [R25]
   end

   // ********************************************************************
   // Registers
   // ********************************************************************
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         state_reg <= STATE_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign axiResp = state_reg.bus;
   assign lineCtrl = state_reg.out;
   assign irqOutN = state_reg.irqN;

endmodule

// ### dv/timing_loopback_ctrl_assertions.sv
// Port checker for the timing and loopback register bank.
// Assumes it is bound to timing_loopback_ctrl and sees only its ports.
`timescale 1ns/100ps
module timing_loopback_ctrl_assertions #(
   parameter logic [17:0] LCD_PERSIST_CYCLES = 18'h10
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire timing_loopback_pkg::axi_req_type axiReq,
   input wire timing_loopback_pkg::axi_resp_type axiResp,
   input wire logic [2:0] lockDetectIn,
   input wire logic [9:0] pointerCtrlIn,
   input wire timing_loopback_pkg::line_ctrl_type lineCtrl,
   input wire logic irqOutN
);
   // ******
   // Cycles since last request
   // ******
   logic [3:0] sinceAcc_reg;
   logic accTaken;
   assign accTaken = (axiReq.awvalid && axiResp.awready) || (axiReq.arvalid && axiResp.arready);
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sinceAcc_reg <= 4'hF;
      end else if (accTaken) begin
         sinceAcc_reg <= 4'h0;
      end else if (sinceAcc_reg != 4'hF) begin
         sinceAcc_reg <= sinceAcc_reg + 4'h1;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // ******
   // Properties
   // ******
   a_unlocked_timing: assert property (lockDetectIn[1] [*8] |->
      ##2 !lineCtrl.txUseRecovered)
      else $error("recovered while unlocked");
   a_pointer_source: assert property ($stable(pointerCtrlIn) [*3] |->
      lineCtrl.payloadPointer == timing_loopback_pkg::FIXED_POINTER_VALUE
      || lineCtrl.payloadPointer == pointerCtrlIn)
      else $error("pointer source");
   // Only an access may release the line
   a_irq_release: assert property ($rose(irqOutN) |-> sinceAcc_reg <= 4'h4)
      else $error("irq release");
   a_read_answer: assert property (axiReq.arvalid && axiResp.arready |=> axiResp.rvalid)
      else $error("read answer late");
   a_write_answer: assert property (axiReq.awvalid && axiResp.awready && axiReq.wvalid
      && axiResp.wready |-> ##[1:2] axiResp.bvalid)
      else $error("write answer late");
   a_upper_zero: assert property (axiResp.rvalid |-> axiResp.rdata[31:8] == 24'h0)
      else $error("upper bits set");
   a_write_busy: assert property (axiResp.bvalid |-> !axiResp.awready && !axiResp.wready)
      else $error("write busy");
   a_read_busy: assert property (axiResp.rvalid |-> !axiResp.arready)
      else $error("read busy");
endmodule
bind timing_loopback_ctrl timing_loopback_ctrl_assertions #(
   .LCD_PERSIST_CYCLES(LCD_PERSIST_CYCLES)) chk (.sys_clk(sys_clk), .nrst(nrst),
   .axiReq(axiReq), .axiResp(axiResp), .lockDetectIn(lockDetectIn),
   .pointerCtrlIn(pointerCtrlIn), .lineCtrl(lineCtrl), .irqOutN(irqOutN));

// ### dv/line_side_model.sv
// Line-side stand-in: lock detectors and cell delineation sources.
// Assumes the bench commands each level; lock levels move off the clock edge.
`timescale 1ns/100ps
module line_side_model (
   input wire logic sys_clk,
   input wire logic [2:0] unlockCmd,
   input wire logic outOfDelinCmd,
   input wire logic alarmCmd,
   output logic [2:0] lockDetectIn,
   output logic cellOutOfDelin,
   output logic lowerAlarm
);
   initial lockDetectIn = 3'h0;
   // Levels land 7ns after the rising edge
   always @(posedge sys_clk) begin
      lockDetectIn <= #7 unlockCmd;
   end
   assign cellOutOfDelin = outOfDelinCmd;
   assign lowerAlarm = alarmCmd;
endmodule

// ### dv/sonet_timing_loopback_ctrl_bench.sv
// Self-checking bench for the timing and loopback register bank.
// Assumes the line-side model on the lock and delineation inputs.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checkCount++; if ((g) !== (e)) begin miscompares++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module sonet_timing_loopback_ctrl_bench;
   localparam logic [1:0] OK = timing_loopback_pkg::RESP_OKAY;
   localparam logic [1:0] ER = timing_loopback_pkg::RESP_SLVERR;
   localparam logic [9:0] FIX = timing_loopback_pkg::FIXED_POINTER_VALUE;
   localparam logic [5:0] IDXS [7] = '{6'h02, 6'h05, 6'h06, 6'h08, 6'h09, 6'h0A, 6'h03};
   localparam logic [7:0] RSTV [7] = '{8'h00, 8'h20, 8'h00, 8'h00, 8'h07, 8'h2C, 8'h00};
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   timing_loopback_pkg::axi_req_type axiReq = '0;
   timing_loopback_pkg::axi_resp_type axiResp;
   timing_loopback_pkg::line_ctrl_type lineCtrl, lx;
   logic [2:0] unlockCmd = 3'h0;
   logic outOfDelinCmd = 1'b0, alarmCmd = 1'b0;
   logic [2:0] lockDetectIn, lk;
   logic cellOutOfDelin, lowerAlarm, irqOutN;
   logic [9:0] pointerCtrlIn = 10'h000;
   logic [34:0] expQ[$];
   logic [34:0] e;
   logic [7:0] v, fl;
   int miscompares = 0;
   int checkCount = 0;
   int m, b;
   initial forever #12.5 sys_clk = ~sys_clk;
   line_side_model partner (.sys_clk(sys_clk), .unlockCmd(unlockCmd),
      .outOfDelinCmd(outOfDelinCmd), .alarmCmd(alarmCmd), .lockDetectIn(lockDetectIn),
      .cellOutOfDelin(cellOutOfDelin), .lowerAlarm(lowerAlarm));
   timing_loopback_ctrl #(.LCD_PERSIST_CYCLES(18'h10)) dut (.sys_clk(sys_clk), .nrst(nrst),
      .axiReq(axiReq), .axiResp(axiResp), .lockDetectIn(lockDetectIn),
      .cellOutOfDelin(cellOutOfDelin), .lowerAlarm(lowerAlarm),
      .pointerCtrlIn(pointerCtrlIn), .lineCtrl(lineCtrl), .irqOutN(irqOutN));
   // ******
   // Bus tasks wait one edge first
   // ******
   task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] r);
      @(posedge sys_clk);
      expQ.push_back({1'b0, r, 32'h0});
      axiReq.awaddr <= {idx, 2'h0};
      axiReq.wdata <= {24'h0, d};
      axiReq.wstrb <= 4'hF;
      axiReq.awvalid <= 1'b1;
      axiReq.wvalid <= 1'b1;
      axiReq.bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (axiResp.awready) axiReq.awvalid <= 1'b0;
         if (axiResp.wready) axiReq.wvalid <= 1'b0;
      end while (axiResp.bvalid !== 1'b1);
      axiReq.bready <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] r);
      @(posedge sys_clk);
      expQ.push_back({1'b1, r, 24'h0, d});
      axiReq.araddr <= {idx, 2'h0};
      axiReq.arvalid <= 1'b1;
      axiReq.rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (axiResp.arready) axiReq.arvalid <= 1'b0;
      end while (axiResp.rvalid !== 1'b1);
      axiReq.rready <= 1'b0;
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checkCount, miscompares);
      if (miscompares == 0 && checkCount > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Oldest note against each answer
   always @(posedge sys_clk) begin
      if (axiResp.bvalid && axiReq.bready || axiResp.rvalid && axiReq.rready) begin
         e = expQ.size() > 0 ? expQ.pop_front() : 35'h7FFFFFFFF;
         if (e[34]) `CHK("rdata", e[33:0], {axiResp.rresp, axiResp.rdata})
         else `CHK("bresp", e[33:32], axiResp.bresp)
      end
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      stop_test;
   end
   initial begin
      void'($urandom(496));
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      for (int i = 0; i < 7; i++) rd(IDXS[i], RSTV[i], i == 6 ? ER : OK);
      `CHK("lineCtrl", {5'h0, FIX, 3'h2}, lineCtrl)
      wr(6'h03, 8'hFF, ER);
      wr(6'h02, 8'hFF, OK);
      rd(6'h05, 8'h20, OK);
      $display("test reset done");
      for (int i = 0; i < 12; i++) begin
         m = $urandom_range(5, 0);
         v = (m < 5 ? 8'h01 << m : 8'h00) | {2'h0, 1'($urandom), 5'h0};
         pointerCtrlIn <= 10'($urandom);
         wr(6'h05, v, OK);
         @(negedge sys_clk);
         lx = {v[0], v[1], v[2], v[3], v[4], v[5] ? FIX : pointerCtrlIn, 3'h2};
         `CHK("lineCtrl", lx, lineCtrl)
         rd(6'h05, v, OK);
      end
      $display("test modes done");
      for (int i = 0; i < 8; i++) begin
         v = {i[2], 1'b0, i[1], i[0], 4'hC};
         wr(6'h0A, v, OK);
         @(negedge sys_clk);
         `CHK("txCtl", {v[4], v[5], v[7]}, lineCtrl[2:0])
         rd(6'h0A, v, OK);
      end
      wr(6'h0A, 8'h2C, OK);
      $display("test driver done");
      wr(6'h05, 8'h01, OK);
      unlockCmd <= 3'h2;
      repeat (10) @(posedge sys_clk);
      `CHK("recovered", 1'b0, lineCtrl.txUseRecovered)
      unlockCmd <= 3'h0;
      repeat (10) @(posedge sys_clk);
      `CHK("recovered", 1'b1, lineCtrl.txUseRecovered)
      rd(6'h08, 8'h20, OK);
      wr(6'h06, 8'h02, OK);
      wr(6'h08, 8'h06, OK);
      lk = 3'h0;
      for (int k = 0; k < 6; k++) begin
         b = k % 3;
         lk[b] = ~lk[b];
         unlockCmd <= lk;
         repeat (8) @(posedge sys_clk);
         `CHK("irqOutN", 1'b0, irqOutN)
         rd(6'h02, b == 0 ? 8'h80 : 8'h20, OK);
         v = b == 0 ? {4'h0, lk[0], 3'h2} : {3'h0, lk[2], lk[1], 3'h6};
         fl = b == 2 ? 8'h40 : 8'h20;
         rd(b == 0 ? 6'h06 : 6'h08, v | fl, OK);
         rd(b == 0 ? 6'h06 : 6'h08, v, OK);
         repeat (4) @(posedge sys_clk);
         `CHK("irqOutN", 1'b1, irqOutN)
      end
      $display("test locks done");
      wr(6'h05, 8'h20, OK);
      outOfDelinCmd <= 1'b1;
      alarmCmd <= 1'b1;
      repeat (40) @(posedge sys_clk);
      rd(6'h05, 8'h20, OK);
      alarmCmd <= 1'b0;
      repeat (24) @(posedge sys_clk);
      `CHK("irqOutN", 1'b1, irqOutN)
      rd(6'h05, 8'h60, OK);
      rd(6'h02, 8'h40, OK);
      rd(6'h02, 8'h00, OK);
      wr(6'h05, 8'hA0, OK);
      outOfDelinCmd <= 1'b0;
      repeat (24) @(posedge sys_clk);
      `CHK("irqOutN", 1'b0, irqOutN)
      rd(6'h05, 8'hA0, OK);
      rd(6'h02, 8'h40, OK);
      repeat (4) @(posedge sys_clk);
      `CHK("irqOutN", 1'b1, irqOutN)
      $display("test delineation done");
      stop_test;
   end
endmodule
